// ### verilog/simd_pkg.sv
package simd_pkg;

  localparam int unsigned SIMD_ADDR_W = 12;
  localparam int unsigned SIMD_NLINES = 7;

  ////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam logic [11:0] SIMD_MODE_OFS = 12'h000;
  localparam logic [11:0] SIMD_CTRL_OFS = 12'h004;
  localparam logic [11:0] SIMD_STAT_OFS = 12'h008;

  localparam int unsigned SIMD_MODE_DRV_LSB = 0;
  localparam int unsigned SIMD_MODE_RCV_LSB = 4;
  localparam int unsigned SIMD_CTRL_TT_N_BIT = 0;
  localparam int unsigned SIMD_CTRL_ST_N_BIT = 1;
  localparam int unsigned SIMD_CTRL_SCT_BIT = 2;
  localparam int unsigned SIMD_STAT_V35_BIT = 0;
  localparam int unsigned SIMD_STAT_V35DRV_BIT = 1;
  localparam int unsigned SIMD_STAT_DRV_LSB = 4;
  localparam int unsigned SIMD_STAT_RCV_LSB = 8;
  localparam int unsigned SIMD_STAT_TERM_BIT = 12;

  localparam logic [3:0] SIMD_WORD_RST = 4'h0;
  localparam logic SIMD_TT_N_RST = 1'b1;
  localparam logic SIMD_ST_N_RST = 1'b1;
  localparam logic SIMD_SCT_RST = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Mode codes, most significant bit first
  localparam logic [3:0] SIMD_CODE_OFF = 4'h0;
  localparam logic [3:0] SIMD_CODE_RS232 = 4'h2;
  localparam logic [3:0] SIMD_CODE_V35 = 4'he;
  localparam logic [3:0] SIMD_CODE_RS422 = 4'h4;
  localparam logic [3:0] SIMD_CODE_RS485 = 4'h5;
  localparam logic [3:0] SIMD_CODE_RS449 = 4'hc;
  localparam logic [3:0] SIMD_CODE_EIA530 = 4'hd;
  localparam logic [3:0] SIMD_CODE_EIA530A = 4'hf;
  localparam logic [3:0] SIMD_CODE_V36 = 4'h6;

  typedef enum logic [3:0] {
    SIMD_M_OFF = 4'b0000,
    SIMD_M_RS232 = 4'b0001,
    SIMD_M_V35 = 4'b0010,
    SIMD_M_RS422 = 4'b0011,
    SIMD_M_RS485 = 4'b0100,
    SIMD_M_RS449 = 4'b0101,
    SIMD_M_EIA530 = 4'b0110,
    SIMD_M_EIA530A = 4'b0111,
    SIMD_M_V36 = 4'b1000,
    SIMD_M_UNDEF = 4'b1001
  } simd_mode_t;

  typedef enum logic [2:0] {
    SIMD_LT_OFF = 3'b000,
    SIMD_LT_V28 = 3'b001,
    SIMD_LT_V10 = 3'b010,
    SIMD_LT_V11 = 3'b011,
    SIMD_LT_RS485 = 3'b100,
    SIMD_LT_V35 = 3'b101
  } simd_ltype_t;

  // Driver line indices
  localparam int SIMD_D_SD = 0;
  localparam int SIMD_D_TR = 1;
  localparam int SIMD_D_RS = 2;
  localparam int SIMD_D_RL = 3;
  localparam int SIMD_D_LL = 4;
  localparam int SIMD_D_ST = 5;
  localparam int SIMD_D_TT = 6;
  // Receiver line indices
  localparam int SIMD_R_RD = 0;
  localparam int SIMD_R_RT = 1;
  localparam int SIMD_R_CS = 2;
  localparam int SIMD_R_DM = 3;
  localparam int SIMD_R_RR = 4;
  localparam int SIMD_R_IC = 5;
  localparam int SIMD_R_SCT = 6;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers and state
  typedef struct packed {
    simd_ltype_t [6:0] kind;
    logic [6:0] en;
  } simd_drv_cfg_t;

  typedef struct packed {
    simd_ltype_t [6:0] kind;
    logic [6:0] out_en;
    logic [6:0] fs_lvl;
    logic [6:0] fs_valid;
  } simd_rcv_cfg_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [3:0] drv_word;
    logic [3:0] rcv_word;
    logic tt_en_n;
    logic st_en_n;
    logic sct_en;
    simd_drv_cfg_t drv_cfg;
    simd_rcv_cfg_t rcv_cfg;
    logic v35_drv_en;
    logic term_en;
    logic v35_status;
  } simd_state_t;

endpackage : simd_pkg

// ### verilog/simd_mode_dec.sv
`timescale 1ns/1ps
`default_nettype none

module simd_mode_dec
  import simd_pkg::*;
(
  input wire logic [3:0] code,
  output simd_mode_t mode
);

  // Code to interface standard, shared by drivers and receivers
  always_comb begin
    case (code)
      SIMD_CODE_OFF: mode = SIMD_M_OFF;
      SIMD_CODE_RS232: mode = SIMD_M_RS232;
      SIMD_CODE_V35: mode = SIMD_M_V35;
      SIMD_CODE_RS422: mode = SIMD_M_RS422;
      SIMD_CODE_RS485: mode = SIMD_M_RS485;
      SIMD_CODE_RS449: mode = SIMD_M_RS449;
      SIMD_CODE_EIA530: mode = SIMD_M_EIA530;
      SIMD_CODE_EIA530A: mode = SIMD_M_EIA530A;
      SIMD_CODE_V36: mode = SIMD_M_V36;
      default: mode = SIMD_M_UNDEF;
    endcase
  end

endmodule : simd_mode_dec

`default_nettype wire

// ### verilog/simd_top.sv
`timescale 1ns/1ps
`default_nettype none

module simd_top
  import simd_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [SIMD_ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic PREADY,
  output logic [31:0] PRDATA,
  output logic PSLVERR,
  output simd_drv_cfg_t DRV_CFG,
  output simd_rcv_cfg_t RCV_CFG,
  output logic V35_DRV_EN,
  output logic TERM_EN,
  output logic V35_STATUS
);

  ////////////////////////////////////////////////////////////////////////////
  // Line type tables

  function automatic simd_ltype_t drv_kind(input simd_mode_t m, input int i);
    simd_ltype_t k;
    k = SIMD_LT_OFF;
    case (m)
      SIMD_M_RS232: k = SIMD_LT_V28;
      SIMD_M_V35: begin
        if (i == SIMD_D_SD || i == SIMD_D_ST || i == SIMD_D_TT) begin
          k = SIMD_LT_V35;
        end else begin
          k = SIMD_LT_V28;
        end
      end
      SIMD_M_RS422: k = SIMD_LT_V11;
      SIMD_M_RS485: k = SIMD_LT_RS485;
      SIMD_M_RS449, SIMD_M_EIA530: begin
        if (i == SIMD_D_RL || i == SIMD_D_LL) begin
          k = SIMD_LT_V10;
        end else begin
          k = SIMD_LT_V11;
        end
      end
      SIMD_M_EIA530A: begin
        if (i == SIMD_D_TR || i == SIMD_D_LL) begin
          k = SIMD_LT_V10;
        end else begin
          k = SIMD_LT_V11;
        end
      end
      SIMD_M_V36: begin
        if (i == SIMD_D_SD || i == SIMD_D_ST || i == SIMD_D_TT) begin
          k = SIMD_LT_V11;
        end else begin
          k = SIMD_LT_V10;
        end
      end
      SIMD_M_OFF: k = SIMD_LT_OFF;
      default: k = SIMD_LT_OFF;
    endcase
    return k;
  endfunction : drv_kind

  function automatic simd_ltype_t rcv_kind(input simd_mode_t m, input int i);
    simd_ltype_t k;
    k = SIMD_LT_OFF;
    case (m)
      SIMD_M_RS232: k = SIMD_LT_V28;
      SIMD_M_V35: begin
        if (i == SIMD_R_RD || i == SIMD_R_RT || i == SIMD_R_SCT) begin
          k = SIMD_LT_V35;
        end else begin
          k = SIMD_LT_V28;
        end
      end
      SIMD_M_RS422: k = SIMD_LT_V11;
      SIMD_M_RS485: k = SIMD_LT_RS485;
      SIMD_M_RS449, SIMD_M_EIA530: begin
        if (i == SIMD_R_IC) begin
          k = SIMD_LT_V10;
        end else begin
          k = SIMD_LT_V11;
        end
      end
      SIMD_M_EIA530A: begin
        if (i == SIMD_R_DM || i == SIMD_R_IC) begin
          k = SIMD_LT_V10;
        end else begin
          k = SIMD_LT_V11;
        end
      end
      SIMD_M_V36: begin
        if (i == SIMD_R_RD || i == SIMD_R_RT || i == SIMD_R_SCT) begin
          k = SIMD_LT_V11;
        end else begin
          k = SIMD_LT_V10;
        end
      end
      SIMD_M_OFF: k = SIMD_LT_OFF;
      default: k = SIMD_LT_OFF;
    endcase
    return k;
  endfunction : rcv_kind

  // Open-input level of a receiver type; bit 1 says a level exists
  function automatic logic [1:0] fail_safe(input simd_ltype_t k);
    logic [1:0] f;
    f = 2'h0;
    case (k)
      SIMD_LT_V28: f = 2'h3;
      SIMD_LT_V10: f = 2'h2;
      SIMD_LT_V11, SIMD_LT_RS485: f = 2'h3;
      SIMD_LT_V35: f = 2'h0;
      default: f = 2'h0;
    endcase
    return f;
  endfunction : fail_safe

  // Register index from address: bit 2 valid, bits 1:0 index
  function automatic logic [2:0] reg_sel(input logic [SIMD_ADDR_W-1:0] a);
    logic [2:0] s;
    s = 3'h0;
    case (a)
      SIMD_MODE_OFS: s = 3'h4;
      SIMD_CTRL_OFS: s = 3'h5;
      SIMD_STAT_OFS: s = 3'h6;
      default: s = 3'h0;
    endcase
    return s;
  endfunction : reg_sel

  ////////////////////////////////////////////////////////////////////////////
  // State and decoders

  simd_state_t st_reg;
  simd_state_t st_next;
  simd_mode_t drv_mode;
  simd_mode_t rcv_mode;

  simd_mode_dec u_drv_dec (
    .code(st_reg.drv_word),
    .mode(drv_mode)
  );

  simd_mode_dec u_rcv_dec (
    .code(st_reg.rcv_word),
    .mode(rcv_mode)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic [2:0] sel;
    logic access;
    logic [31:0] rd;
    logic [1:0] fs;
    sel = reg_sel(PADDR);
    access = PSEL & PENABLE;
    rd = 32'h0;
    fs = 2'h0;
    st_next = st_reg;

    // APB slave: one wait state, write lands on the pready edge
    st_next.pready = access & ~st_reg.pready;
    st_next.pslverr = access & ~st_reg.pready & ~sel[2];
    if (access & st_reg.pready & PWRITE & sel[2] & PSTRB[0]) begin
      case (sel[1:0])
        2'h0: begin
          st_next.drv_word = PWDATA[SIMD_MODE_DRV_LSB +: 4];
          st_next.rcv_word = PWDATA[SIMD_MODE_RCV_LSB +: 4];
        end
        2'h1: begin
          st_next.tt_en_n = PWDATA[SIMD_CTRL_TT_N_BIT];
          st_next.st_en_n = PWDATA[SIMD_CTRL_ST_N_BIT];
          st_next.sct_en = PWDATA[SIMD_CTRL_SCT_BIT];
        end
        default: begin
        end
      endcase
    end
    case (sel)
      3'h4: begin
        rd[SIMD_MODE_DRV_LSB +: 4] = st_reg.drv_word;
        rd[SIMD_MODE_RCV_LSB +: 4] = st_reg.rcv_word;
      end
      3'h5: begin
        rd[SIMD_CTRL_TT_N_BIT] = st_reg.tt_en_n;
        rd[SIMD_CTRL_ST_N_BIT] = st_reg.st_en_n;
        rd[SIMD_CTRL_SCT_BIT] = st_reg.sct_en;
      end
      3'h6: begin
        rd[SIMD_STAT_V35_BIT] = st_reg.v35_status;
        rd[SIMD_STAT_V35DRV_BIT] = st_reg.v35_drv_en;
        rd[SIMD_STAT_DRV_LSB +: 4] = drv_mode;
        rd[SIMD_STAT_RCV_LSB +: 4] = rcv_mode;
        rd[SIMD_STAT_TERM_BIT] = st_reg.term_en;
      end
      default: rd = 32'h0;
    endcase
    if (access & ~st_reg.pready & ~PWRITE) begin
      st_next.prdata = rd;
    end else if (~access) begin
      st_next.prdata = 32'h0;
    end

    // Per-line configuration from the decoded modes
    for (int i = 0; i < SIMD_NLINES; i++) begin
      st_next.drv_cfg.kind[i] = drv_kind(drv_mode, i);
      st_next.drv_cfg.en[i] = (drv_kind(drv_mode, i) != SIMD_LT_OFF);
      st_next.rcv_cfg.kind[i] = rcv_kind(rcv_mode, i);
      st_next.rcv_cfg.out_en[i] = (rcv_kind(rcv_mode, i) != SIMD_LT_OFF);
      fs = fail_safe(rcv_kind(rcv_mode, i));
      st_next.rcv_cfg.fs_lvl[i] = fs[0];
      st_next.rcv_cfg.fs_valid[i] = fs[1];
    end
    if (st_reg.tt_en_n) begin
      st_next.drv_cfg.en[SIMD_D_TT] = 1'b0;
    end
    if (st_reg.st_en_n) begin
      st_next.drv_cfg.en[SIMD_D_ST] = 1'b0;
    end
    st_next.rcv_cfg.out_en[SIMD_R_SCT] = st_reg.sct_en &
        (rcv_kind(rcv_mode, SIMD_R_SCT) != SIMD_LT_OFF);

    st_next.v35_drv_en = (drv_mode == SIMD_M_V35);
    st_next.term_en = (rcv_mode == SIMD_M_V35);
    st_next.v35_status = (drv_mode == SIMD_M_V35);
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      st_reg <= '0;
      st_reg.drv_word <= SIMD_WORD_RST;
      st_reg.rcv_word <= SIMD_WORD_RST;
      st_reg.tt_en_n <= SIMD_TT_N_RST;
      st_reg.st_en_n <= SIMD_ST_N_RST;
      st_reg.sct_en <= SIMD_SCT_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign PREADY = st_reg.pready;
  assign PRDATA = st_reg.prdata;
  assign PSLVERR = st_reg.pslverr;
  assign DRV_CFG = st_reg.drv_cfg;
  assign RCV_CFG = st_reg.rcv_cfg;
  assign V35_DRV_EN = st_reg.v35_drv_en;
  assign TERM_EN = st_reg.term_en;
  assign V35_STATUS = st_reg.v35_status;

endmodule : simd_top

`default_nettype wire

// ### verif/simd_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
module simd_top_sva
  import simd_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [SIMD_ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  input wire logic PREADY,
  input wire logic [31:0] PRDATA,
  input wire logic PSLVERR,
  input wire simd_drv_cfg_t DRV_CFG,
  input wire simd_rcv_cfg_t RCV_CFG,
  input wire logic V35_DRV_EN,
  input wire logic TERM_EN,
  input wire logic V35_STATUS
);
  logic wr;
  logic wmode;
  logic wctrl;
  logic drv_undef;
  logic [6:0] fs_bad;
  assign wr = PSEL && PENABLE && PREADY && PWRITE && PSTRB[0];
  assign wmode = wr && (PADDR == SIMD_MODE_OFS);
  assign wctrl = wr && (PADDR == SIMD_CTRL_OFS);
  assign drv_undef = wmode && !(PWDATA[3:0] inside {SIMD_CODE_OFF,
    SIMD_CODE_RS232, SIMD_CODE_V35, SIMD_CODE_RS422, SIMD_CODE_RS485,
    SIMD_CODE_RS449, SIMD_CODE_EIA530, SIMD_CODE_EIA530A, SIMD_CODE_V36});
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      case (RCV_CFG.kind[i])
        SIMD_LT_V10: fs_bad[i] = !RCV_CFG.fs_valid[i] || RCV_CFG.fs_lvl[i];
        SIMD_LT_V28, SIMD_LT_V11, SIMD_LT_RS485:
          fs_bad[i] = !RCV_CFG.fs_valid[i] || !RCV_CFG.fs_lvl[i];
        default: fs_bad[i] = RCV_CFG.fs_valid[i];
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  drv_off_a: assert property (
    wmode && PWDATA[3:0] == SIMD_CODE_OFF |-> ##2 DRV_CFG.en == 7'h00)
    else $error("drivers enabled after off code");
  rcv_off_a: assert property (
    wmode && PWDATA[7:4] == SIMD_CODE_OFF |-> ##2 RCV_CFG.out_en == 7'h00)
    else $error("receivers enabled after off code");
  v35_on_a: assert property (
    wmode && PWDATA[3:0] == SIMD_CODE_V35 |-> ##2 V35_STATUS && V35_DRV_EN)
    else $error("v35 status missing");
  v35_drv_a: assert property (
    V35_DRV_EN == (DRV_CFG.kind[SIMD_D_SD] == SIMD_LT_V35) &&
    V35_STATUS == V35_DRV_EN) else $error("v35 driver enable mismatch");
  term_sw_a: assert property (
    TERM_EN == (RCV_CFG.kind[SIMD_R_RD] == SIMD_LT_V35))
    else $error("termination mismatch");
  fs_level_a: assert property (fs_bad == 7'h00)
    else $error("fail-safe level wrong");
  undef_off_a: assert property (
    drv_undef |-> ##2 !V35_STATUS && DRV_CFG.en == 7'h00)
    else $error("undefined code enabled drivers");
  tt_gate_a: assert property (
    wctrl && PWDATA[SIMD_CTRL_TT_N_BIT] |-> ##2 !DRV_CFG.en[SIMD_D_TT])
    else $error("terminal timing driver enabled");
  sct_gate_a: assert property (
    wctrl && !PWDATA[SIMD_CTRL_SCT_BIT] |-> ##2 !RCV_CFG.out_en[SIMD_R_SCT])
    else $error("clock timing receiver enabled");
  no_latch_a: assert property (
    $changed(DRV_CFG) |-> $past(wr) || $past(wr, 2))
    else $error("driver config changed without write");
  cover property (V35_STATUS);
  cover property (TERM_EN);
  cover property (PSLVERR);
  cover property (wctrl ##2 DRV_CFG.en[SIMD_D_TT]);
endmodule : simd_top_sva
bind simd_top simd_top_sva u_simd_top_sva (.SYS_CLK(SYS_CLK), .RST(RST),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PWDATA(PWDATA), .PSTRB(PSTRB), .PREADY(PREADY), .PRDATA(PRDATA),
  .PSLVERR(PSLVERR), .DRV_CFG(DRV_CFG), .RCV_CFG(RCV_CFG),
  .V35_DRV_EN(V35_DRV_EN), .TERM_EN(TERM_EN), .V35_STATUS(V35_STATUS));
`default_nettype wire

// ### verif/simd_far_end.sv
`timescale 1ns/1ps
`default_nettype none
module simd_far_end
  import simd_pkg::*;
(
  input wire simd_ltype_t [6:0] line_kind,
  output logic [6:0] open_lvl,
  output logic [6:0] has_fs
);
  // Remote end unplugged: level each receiver shows with open inputs
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      case (line_kind[i])
        SIMD_LT_V28: {open_lvl[i], has_fs[i]} = 2'b11;
        SIMD_LT_V10: {open_lvl[i], has_fs[i]} = 2'b01;
        SIMD_LT_V11, SIMD_LT_RS485: {open_lvl[i], has_fs[i]} = 2'b11;
        default: {open_lvl[i], has_fs[i]} = 2'b00;
      endcase
    end
  end
endmodule : simd_far_end
`default_nettype wire

// ### verif/tb_serial_interface_mode_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module tb_serial_interface_mode_decoder
  import simd_pkg::*;
;
  localparam logic [6:0] drv_cd = 7'h61, drv_449 = 7'h18, drv_530a = 7'h12;
  localparam logic [6:0] rcv_cd = 7'h43, rcv_449 = 7'h20, rcv_530a = 7'h28;
  // Defined codes only, in mode order
  localparam logic [3:0] mode_codes [0:8] = '{SIMD_CODE_OFF, SIMD_CODE_RS232,
    SIMD_CODE_V35, SIMD_CODE_RS422, SIMD_CODE_RS485, SIMD_CODE_RS449,
    SIMD_CODE_EIA530, SIMD_CODE_EIA530A, SIMD_CODE_V36};
  logic sys_clk = 1'b0, rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic pready, pslverr, v35_drv_en, term_en, v35_status;
  logic [31:0] prdata;
  simd_drv_cfg_t drv_cfg;
  simd_rcv_cfg_t rcv_cfg;
  simd_ltype_t [6:0] exp_rk = '0;
  logic [6:0] open_lvl, has_fs;
  int fail_count = 0, check_count = 0, cyc = 0;
  always #2 sys_clk = ~sys_clk;
  simd_top u_simd_top (.SYS_CLK(sys_clk), .RST(rst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PSTRB(pstrb), .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr),
    .DRV_CFG(drv_cfg), .RCV_CFG(rcv_cfg), .V35_DRV_EN(v35_drv_en),
    .TERM_EN(term_en), .V35_STATUS(v35_status));
  simd_far_end u_simd_far_end (.line_kind(exp_rk), .open_lvl(open_lvl),
    .has_fs(has_fs));
  ////////////////////////////////////////////////////////////////////////////
  task tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  task chk(input string name, input logic [63:0] seen, input logic [63:0] e);
    check_count++;
    if (seen !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, e, seen);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      input logic [3:0] s, output logic [31:0] r, output logic e);
    int n;
    @(posedge sys_clk);
    {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, d, s};
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1);
    chk("pready_wait", n, 2);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, 4'hf, r, e);
    chk("wr_err", e, 1'b0);
    repeat (3) @(posedge sys_clk);
  endtask : wr
  task rd(input logic [11:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, 4'hf, r, e);
    chk("rd_err", e, 1'b0);
  endtask : rd
  function automatic simd_ltype_t exp_kind(input logic [3:0] c,
      input logic cd, input logic s449, input logic s530a);
    case (c)
      SIMD_CODE_RS232: return SIMD_LT_V28;
      SIMD_CODE_V35: return cd ? SIMD_LT_V35 : SIMD_LT_V28;
      SIMD_CODE_RS422: return SIMD_LT_V11;
      SIMD_CODE_RS485: return SIMD_LT_RS485;
      SIMD_CODE_RS449, SIMD_CODE_EIA530: return s449 ? SIMD_LT_V10 : SIMD_LT_V11;
      SIMD_CODE_EIA530A: return s530a ? SIMD_LT_V10 : SIMD_LT_V11;
      SIMD_CODE_V36: return cd ? SIMD_LT_V11 : SIMD_LT_V10;
      default: return SIMD_LT_OFF;
    endcase
  endfunction : exp_kind
  task check_cfg(input logic [3:0] dc, input logic [3:0] rc);
    simd_ltype_t k;
    for (int i = 0; i < 7; i++) begin
      exp_rk[i] = exp_kind(rc, rcv_cd[i], rcv_449[i], rcv_530a[i]);
    end
    #1;
    for (int i = 0; i < 7; i++) begin
      k = exp_kind(dc, drv_cd[i], drv_449[i], drv_530a[i]);
      chk("drv_kind", drv_cfg.kind[i], k);
      chk("drv_en", drv_cfg.en[i], k != SIMD_LT_OFF);
      chk("rcv_kind", rcv_cfg.kind[i], exp_rk[i]);
      chk("rcv_en", rcv_cfg.out_en[i], exp_rk[i] != SIMD_LT_OFF);
      chk("fs_valid", rcv_cfg.fs_valid[i], has_fs[i]);
      if (has_fs[i]) chk("fs_lvl", rcv_cfg.fs_lvl[i], open_lvl[i]);
    end
    chk("v35_status", v35_status, dc == SIMD_CODE_V35);
    chk("v35_drv_en", v35_drv_en, dc == SIMD_CODE_V35);
    chk("term_en", term_en, rc == SIMD_CODE_V35);
  endtask : check_cfg
  ////////////////////////////////////////////////////////////////////////////
  task t_reset;
    logic [31:0] r;
    rd(SIMD_MODE_OFS, r);
    chk("mode_rst", r, {24'h0, SIMD_WORD_RST, SIMD_WORD_RST});
    rd(SIMD_CTRL_OFS, r);
    chk("ctrl_rst", r, {29'h0, SIMD_SCT_RST, SIMD_ST_N_RST, SIMD_TT_N_RST});
    rd(SIMD_STAT_OFS, r);
    chk("stat_rst", r, 32'h0);
    check_cfg(SIMD_CODE_OFF, SIMD_CODE_OFF);
    $display("t_reset done");
  endtask : t_reset
  task t_codes;
    logic [31:0] r;
    logic [3:0] m;
    logic [3:0] c;
    wr(SIMD_CTRL_OFS, 32'h4);
    for (int n = 0; n < 16; n++) begin
      c = 4'(n);
      m = 4'h9;
      for (int j = 0; j < 9; j++) if (mode_codes[j] == c) m = 4'(j);
      wr(SIMD_MODE_OFS, {24'h0, c, c});
      check_cfg(c, c);
      rd(SIMD_STAT_OFS, r);
      chk("stat_modes", r[11:4], {m, m});
    end
    $display("t_codes done");
  endtask : t_codes
  task t_indep;
    wr(SIMD_MODE_OFS, {24'h0, SIMD_CODE_RS232, SIMD_CODE_V35});
    check_cfg(SIMD_CODE_V35, SIMD_CODE_RS232);
    wr(SIMD_MODE_OFS, {24'h0, SIMD_CODE_V35, SIMD_CODE_RS422});
    check_cfg(SIMD_CODE_RS422, SIMD_CODE_V35);
    $display("t_indep done");
  endtask : t_indep
  task t_ctrl;
    wr(SIMD_MODE_OFS, {24'h0, SIMD_CODE_RS422, SIMD_CODE_RS422});
    wr(SIMD_CTRL_OFS, 32'h3);
    chk("en_off", {drv_cfg.en[SIMD_D_TT], drv_cfg.en[SIMD_D_ST]}, 2'b00);
    chk("sd_en", drv_cfg.en[SIMD_D_SD], 1'b1);
    chk("sct_off", rcv_cfg.out_en[SIMD_R_SCT], 1'b0);
    wr(SIMD_CTRL_OFS, 32'h6);
    chk("en_tt", {drv_cfg.en[SIMD_D_TT], drv_cfg.en[SIMD_D_ST]}, 2'b10);
    chk("sct_on", rcv_cfg.out_en[SIMD_R_SCT], 1'b1);
    wr(SIMD_MODE_OFS, {24'h0, SIMD_CODE_OFF, SIMD_CODE_RS422});
    chk("sct_ovr", rcv_cfg.out_en[SIMD_R_SCT], 1'b0);
    $display("t_ctrl done");
  endtask : t_ctrl
  task t_bus;
    logic [31:0] r;
    logic e;
    apb(1'b0, 12'h00c, 32'h0, 4'hf, r, e);
    chk("unmapped_err", e, 1'b1);
    chk("unmapped_data", r, 32'h0);
    apb(1'b1, SIMD_MODE_OFS, 32'h22, 4'h0, r, e);
    chk("strb_err", e, 1'b0);
    wr(SIMD_STAT_OFS, 32'hffff);
    rd(SIMD_MODE_OFS, r);
    chk("strb_ignored", r, {24'h0, SIMD_CODE_OFF, SIMD_CODE_RS422});
    $display("t_bus done");
  endtask : t_bus
  task t_midrst;
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    $display("t_midrst done");
  endtask : t_midrst
  initial begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_codes();
    t_indep();
    t_ctrl();
    t_bus();
    t_midrst();
    tally_and_finish();
  end
endmodule : tb_serial_interface_mode_decoder
`default_nettype wire
